// ### common/clock_reset_power_modes_consts.vh
// Constants for the clock-mode, reset and low-power controller.
// Assumes byte addressing on the register bus, one 32-bit word per register.
`ifndef CLOCK_RESET_POWER_MODES_CONSTS_VH
`define CLOCK_RESET_POWER_MODES_CONSTS_VH

// Register byte offsets.
`define CRPM_ADDR_CLOCK_MODE    5'h00
`define CRPM_ADDR_AUX_CTRL      5'h04
`define CRPM_ADDR_POWER_CTRL    5'h08
`define CRPM_ADDR_IRQ_CFG       5'h0C
`define CRPM_ADDR_STATUS        5'h10

// Field positions.
`define CRPM_BIT_SPEED_SEL      0
`define CRPM_BIT_PROGMEM_PD     4
`define CRPM_BIT_IDLE_REQ       0
`define CRPM_BIT_PD_REQ         1
`define CRPM_BIT_IRQ0_EN        0
`define CRPM_BIT_IRQ0_LEVEL     1
`define CRPM_BIT_IRQ1_EN        2
`define CRPM_BIT_IRQ1_LEVEL     3
`define CRPM_BIT_ST_SIX_CLK     0
`define CRPM_BIT_ST_IDLE        1
`define CRPM_BIT_ST_PD          2
`define CRPM_BIT_ST_OSC_RUN     3
`define CRPM_BIT_ST_EXT_FETCH   4
`define CRPM_BIT_ST_FUSE        5

// Reset values.
`define CRPM_RST_SPEED_SEL      1'h0
`define CRPM_RST_PROGMEM_PD     1'h0
`define CRPM_RST_IRQ_CFG        4'h0

// Timing counts.
`define CRPM_PERIODS_SIX_CLK    4'h6
`define CRPM_PERIODS_TWELVE_CLK 4'hC
`define CRPM_RESET_MACHINE_CYC  2'h2

`endif

// ### hdl/clock_reset_power_modes.v
// Clock-mode select, reset qualification and idle / power-down control of a small processor.
// Assumes mclk is the oscillator itself and that the core obeys the enables and resets given here.
`include "clock_reset_power_modes_consts.vh"
`default_nettype none
module clock_reset_power_modes (
    input  wire        mclk,
    input  wire        resetn,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        rst_pin,
    input  wire        speed_double_fuse,
    input  wire        external_fetch_select_pin,
    input  wire        ext_irq_zero,
    input  wire        ext_irq_one,
    input  wire        irq_pending,
    input  wire [1:0]  serial_mode,
    input  wire        timer_baud_tick,
    output reg         osc_enable_r,
    output reg         machine_cycle_r,
    output reg         cpu_step_r,
    output reg         periph_step_r,
    output reg         serial_tick_r,
    output reg         core_reset_r,
    output reg         port_reset_r,
    output reg         ext_fetch_latched_r,
    output reg         progmem_analog_pd_r,
    output reg         wake_irq_zero_r,
    output reg         wake_irq_one_r
);
    localparam [2:0] ST_RUN     = 3'h0;
    localparam [2:0] ST_IDLE    = 3'h1;
    localparam [2:0] ST_PD_WAIT = 3'h2;
    localparam [2:0] ST_PD      = 3'h3;
    localparam [2:0] ST_PD_WAKE = 3'h4;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         speed_double_select_bit_r;
    reg         progmem_analog_powerdown_bit_r;
    reg  [3:0]  irq_cfg_r;
    reg         wake_src_zero_r;
    reg         wake_src_one_r;
    reg         reset_seen_r;
    reg  [31:0] read_value;

    wire        six_clk_mode;
    wire        mc_strobe;
    wire        reset_taken;
    wire        sfr_reset;
    wire        bus_req;
    wire        bus_write_now;
    wire        osc_run;
    wire        cpu_running;
    wire        periph_running;
    wire        wake_low_zero;
    wire        wake_low_one;
    wire        wake_low_any;
    wire        write_power;

    assign six_clk_mode = speed_double_fuse | speed_double_select_bit_r;

    reset_pin_qualifier #(
        .MIN_MACHINE_CYCLES (`CRPM_RESET_MACHINE_CYC)
    ) u_reset_qualifier (
        .mclk          (mclk),
        .resetn        (resetn),
        .rst_pin       (rst_pin),
        .mc_strobe     (mc_strobe),
        .reset_taken_r (reset_taken)
    );

    machine_cycle_divider u_divider (
        .mclk         (mclk),
        .resetn       (resetn),
        .run          (osc_run),
        .six_clk_mode (six_clk_mode),
        .mc_strobe_r  (mc_strobe)
    );

    assign osc_run = (state_r != ST_PD) || rst_pin;

    assign sfr_reset      = reset_taken;
    assign bus_req        = avs_read | avs_write;
    assign bus_write_now  = avs_write && !avs_waitrequest;
    assign write_power    = bus_write_now && (avs_address == `CRPM_ADDR_POWER_CTRL);
    assign cpu_running    = (state_r == ST_RUN) || (state_r == ST_PD_WAIT);
    assign periph_running = cpu_running || (state_r == ST_IDLE);

    assign wake_low_zero = irq_cfg_r[`CRPM_BIT_IRQ0_EN] && irq_cfg_r[`CRPM_BIT_IRQ0_LEVEL] && !ext_irq_zero;
    assign wake_low_one  = irq_cfg_r[`CRPM_BIT_IRQ1_EN] && irq_cfg_r[`CRPM_BIT_IRQ1_LEVEL] && !ext_irq_one;
    assign wake_low_any  = wake_low_zero | wake_low_one;

    // Slave answers one cycle after the request; the access completes at the waitrequest-low edge.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? read_value : 32'h00000000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always @* begin
        read_value = 32'h00000000;
        case (avs_address)
            `CRPM_ADDR_CLOCK_MODE: begin
                read_value[`CRPM_BIT_SPEED_SEL] = speed_double_select_bit_r;
            end
            `CRPM_ADDR_AUX_CTRL: begin
                read_value[`CRPM_BIT_PROGMEM_PD] = progmem_analog_powerdown_bit_r;
            end
            `CRPM_ADDR_POWER_CTRL: begin
                read_value[`CRPM_BIT_IDLE_REQ] = (state_r == ST_IDLE);
                read_value[`CRPM_BIT_PD_REQ]   = (state_r == ST_PD_WAIT);
            end
            `CRPM_ADDR_IRQ_CFG: begin
                read_value[3:0] = irq_cfg_r;
            end
            `CRPM_ADDR_STATUS: begin
                read_value[`CRPM_BIT_ST_SIX_CLK]   = six_clk_mode;
                read_value[`CRPM_BIT_ST_IDLE]      = (state_r == ST_IDLE);
                read_value[`CRPM_BIT_ST_PD]        = (state_r == ST_PD) || (state_r == ST_PD_WAKE);
                read_value[`CRPM_BIT_ST_OSC_RUN]   = osc_run;
                read_value[`CRPM_BIT_ST_EXT_FETCH] = ext_fetch_latched_r;
                read_value[`CRPM_BIT_ST_FUSE]      = speed_double_fuse;
            end
            default: begin
                read_value = 32'h00000000;
            end
        endcase
    end

    // Registers only change on their own events, so a stopped clock keeps them.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            speed_double_select_bit_r      <= `CRPM_RST_SPEED_SEL;
            progmem_analog_powerdown_bit_r <= `CRPM_RST_PROGMEM_PD;
            irq_cfg_r                      <= `CRPM_RST_IRQ_CFG;
        end else if (sfr_reset) begin
            speed_double_select_bit_r      <= `CRPM_RST_SPEED_SEL;
            progmem_analog_powerdown_bit_r <= `CRPM_RST_PROGMEM_PD;
            irq_cfg_r                      <= `CRPM_RST_IRQ_CFG;
        end else if (bus_write_now) begin
            if (avs_address == `CRPM_ADDR_CLOCK_MODE) begin
                speed_double_select_bit_r <= avs_writedata[`CRPM_BIT_SPEED_SEL];
            end
            if (avs_address == `CRPM_ADDR_AUX_CTRL) begin
                progmem_analog_powerdown_bit_r <= avs_writedata[`CRPM_BIT_PROGMEM_PD];
            end
            if (avs_address == `CRPM_ADDR_IRQ_CFG) begin
                irq_cfg_r <= avs_writedata[3:0];
            end
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (write_power && avs_writedata[`CRPM_BIT_PD_REQ]) begin
                    state_nxt = ST_PD_WAIT;
                end else if (write_power && avs_writedata[`CRPM_BIT_IDLE_REQ]) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (irq_pending) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_PD_WAIT: begin
                // Stop after the current machine cycle completes.
                if (mc_strobe) begin
                    state_nxt = ST_PD;
                end
            end
            ST_PD: begin
                if (wake_low_any) begin
                    state_nxt = ST_PD_WAKE;
                end
            end
            ST_PD_WAKE: begin
                if (!wake_low_any) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Hardware reset restarts as from power-on.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_RUN;
        end else if (sfr_reset) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Remember which pin woke the device.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wake_src_zero_r <= 1'b0;
            wake_src_one_r  <= 1'b0;
            wake_irq_zero_r <= 1'b0;
            wake_irq_one_r  <= 1'b0;
        end else if (sfr_reset) begin
            wake_src_zero_r <= 1'b0;
            wake_src_one_r  <= 1'b0;
            wake_irq_zero_r <= 1'b0;
            wake_irq_one_r  <= 1'b0;
        end else begin
            if (state_r == ST_PD && wake_low_any) begin
                wake_src_zero_r <= wake_low_zero;
                wake_src_one_r  <= wake_low_one;
            end
            // State kept, so the core resumes after the power-down instruction.
            wake_irq_zero_r <= (state_r == ST_PD_WAKE) && !wake_low_any && wake_src_zero_r;
            wake_irq_one_r  <= (state_r == ST_PD_WAKE) && !wake_low_any && wake_src_one_r;
        end
    end

    // Ports forced while the pin is high, without a clock.
    always @(posedge mclk or negedge resetn or posedge rst_pin) begin
        if (!resetn) begin
            port_reset_r <= 1'b1;
        end else if (rst_pin) begin
            port_reset_r <= 1'b1;
        end else begin
            port_reset_r <= core_reset_r;
        end
    end

    // Capture fetch select at reset release.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reset_seen_r        <= 1'b1;
            ext_fetch_latched_r <= 1'b0;
        end else begin
            reset_seen_r <= reset_taken;
            if (reset_seen_r && !reset_taken) begin
                ext_fetch_latched_r <= external_fetch_select_pin;
            end
        end
    end

    // Every output of the block leaves through a flip-flop to keep the core's timing clean.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            osc_enable_r        <= 1'b1;
            machine_cycle_r     <= 1'b0;
            cpu_step_r          <= 1'b0;
            periph_step_r       <= 1'b0;
            serial_tick_r       <= 1'b0;
            core_reset_r        <= 1'b1;
            progmem_analog_pd_r <= 1'b0;
        end else begin
            osc_enable_r        <= osc_run;
            machine_cycle_r     <= mc_strobe;
            // CPU steps only outside idle and power-down.
            cpu_step_r          <= mc_strobe && cpu_running && !reset_taken;
            periph_step_r       <= mc_strobe && periph_running;
            // Divider only for modes 0 and 2.
            serial_tick_r       <= periph_running &&
                                   (serial_mode[0] ? timer_baud_tick : mc_strobe);
            core_reset_r        <= reset_taken;
            progmem_analog_pd_r <= progmem_analog_powerdown_bit_r;
        end
    end

endmodule
`default_nettype wire

// ### hdl/machine_cycle_divider.v
// Divides the oscillator clock into one machine-cycle strobe per 6 or 12 periods.
// Assumes mclk is the oscillator; run low freezes the count as a stopped oscillator would.
`include "clock_reset_power_modes_consts.vh"
`default_nettype none
module machine_cycle_divider (
    input  wire       mclk,
    input  wire       resetn,
    input  wire       run,
    input  wire       six_clk_mode,
    output reg        mc_strobe_r
);
    reg  [3:0] count_r;
    wire [3:0] last_count;

    assign last_count = six_clk_mode ? (`CRPM_PERIODS_SIX_CLK - 4'h1) : (`CRPM_PERIODS_TWELVE_CLK - 4'h1);

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_r     <= 4'h0;
            mc_strobe_r <= 1'b0;
        end else if (run) begin
            if (count_r >= last_count) begin
                count_r     <= 4'h0;
                mc_strobe_r <= 1'b1;
            end else begin
                count_r     <= count_r + 4'h1;
                mc_strobe_r <= 1'b0;
            end
        end else begin
            mc_strobe_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/reset_pin_qualifier.v
// Accepts the reset pin only after it has stayed high for a set number of machine cycles.
// Assumes the pin is synchronous to mclk and that mc_strobe runs while the oscillator runs.
`include "clock_reset_power_modes_consts.vh"
`default_nettype none
module reset_pin_qualifier #(
    parameter [1:0] MIN_MACHINE_CYCLES = `CRPM_RESET_MACHINE_CYC
) (
    input  wire       mclk,
    input  wire       resetn,
    input  wire       rst_pin,
    input  wire       mc_strobe,
    output reg        reset_taken_r
);
    reg [1:0] held_r;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            held_r        <= 2'h0;
            reset_taken_r <= 1'b0;
        end else if (!rst_pin) begin
            held_r        <= 2'h0;
            reset_taken_r <= 1'b0;
        end else if (mc_strobe && !reset_taken_r) begin
            if (held_r + 2'h1 >= MIN_MACHINE_CYCLES) begin
                reset_taken_r <= 1'b1;
            end
            held_r <= held_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/clock_reset_power_modes_chk.sv
// Port-level checks for the clock, reset and power-mode controller.
// Assumes a single clock mclk and the asynchronous active-low resetn.
`default_nettype none
module clock_reset_power_modes_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic rst_pin,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic speed_double_fuse,
    input wire logic osc_enable_r,
    input wire logic machine_cycle_r,
    input wire logic core_reset_r,
    input wire logic port_reset_r,
    input wire logic ext_fetch_latched_r,
    input wire logic wake_irq_zero_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] hold_cnt_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Saturates so that a long pin pulse cannot wrap back into the early window.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt_r <= 6'h00;
        end else if (!rst_pin) begin
            hold_cnt_r <= 6'h00;
        end else if (hold_cnt_r != 6'h3F) begin
            hold_cnt_r <= hold_cnt_r + 6'h01;
        end
    end
    a_wait_answer : assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus request not answered");
    a_wait_pulse : assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    a_port_async : assert property (
        rst_pin |-> port_reset_r) else $error("port reset missing while reset pin high");
    a_strobe_spacing : assert property (
        machine_cycle_r |=> !machine_cycle_r [*5]) else $error("machine strobes too close");
    a_six_clk_period : assert property (
        machine_cycle_r && speed_double_fuse |-> ##6 (machine_cycle_r || !osc_enable_r)) else $error("fuse period wrong");
    a_reset_not_early : assert property (
        $rose(core_reset_r) |-> hold_cnt_r >= 6'h06) else $error("core reset taken too early");
    a_reset_taken : assert property (
        hold_cnt_r >= 6'h2D |-> core_reset_r) else $error("core reset not taken");
    a_fetch_held : assert property (
        !core_reset_r && !$past(core_reset_r) && !$past(core_reset_r, 2) |-> $stable(ext_fetch_latched_r))
        else $error("fetch select changed outside reset");
    a_osc_stop_strobe : assert property (
        $fell(osc_enable_r) |-> $past(machine_cycle_r) || $past(machine_cycle_r, 2)) else $error("osc stopped off strobe");
    a_pd_held : assert property (
        !osc_enable_r && ext_irq_zero && ext_irq_one && !rst_pin |=> !osc_enable_r) else $error("power-down left early");
    a_wake_pulse : assert property (
        wake_irq_zero_r |-> ext_irq_zero && osc_enable_r ##1 !wake_irq_zero_r) else $error("wake pulse wrong");
endmodule
bind clock_reset_power_modes clock_reset_power_modes_chk chk_inst (.mclk(mclk), .resetn(resetn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rst_pin(rst_pin),
    .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one), .speed_double_fuse(speed_double_fuse),
    .osc_enable_r(osc_enable_r), .machine_cycle_r(machine_cycle_r), .core_reset_r(core_reset_r),
    .port_reset_r(port_reset_r), .ext_fetch_latched_r(ext_fetch_latched_r), .wake_irq_zero_r(wake_irq_zero_r));
`default_nettype wire

// ### verif/reset_irq_source.sv
// Model of the outside reset circuit, the external interrupt pins and the baud timer.
// Assumes the bench asks for a reset or wake by a one-cycle pulse on mclk.
`default_nettype none
module reset_irq_source #(
    parameter int STARTUP  = 60,
    parameter int SETTLE   = 20,
    parameter int BAUD_DIV = 5
) (
    input  wire logic mclk,
    input  wire logic pulse_rst,
    input  wire logic pulse_wake0,
    input  wire logic pulse_wake1,
    output var  logic rst_pin,
    output var  logic ext_irq_zero,
    output var  logic ext_irq_one,
    output var  logic timer_baud_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    int rst_left = STARTUP;
    int w0_left  = 0;
    int w1_left  = 0;
    int baud_cnt = 0;
    // Pins held long enough for start-up and oscillator restart.
    always @(posedge mclk) begin
        rst_left <= pulse_rst ? STARTUP : (rst_left > 0 ? rst_left - 1 : 0);
        w0_left  <= pulse_wake0 ? SETTLE : (w0_left > 0 ? w0_left - 1 : 0);
        w1_left  <= pulse_wake1 ? SETTLE : (w1_left > 0 ? w1_left - 1 : 0);
        baud_cnt <= (baud_cnt == BAUD_DIV - 1) ? 0 : baud_cnt + 1;
    end
    // The interrupt pins have pull-ups, so a released pin reads high.
    assign rst_pin         = (rst_left != 0);
    assign ext_irq_zero    = (w0_left == 0);
    assign ext_irq_one     = (w1_left == 0);
    assign timer_baud_tick = (baud_cnt == 0);
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the clock, reset and power-mode controller.
// Assumes the bound checker and the reset and interrupt source model.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, resetn, avs_read, avs_write, avs_waitrequest, fuse, fetch_pin, irq_pending;
    logic        pulse_rst, pulse_wake0, pulse_wake1, rst_pin, irq0, irq1, baud;
    logic [4:0]  avs_address;
    logic [1:0]  serial_mode;
    logic [31:0] avs_writedata, avs_readdata;
    logic        osc, mc, cpu, per, ser, core_reset_r, port_reset_r, fetch_r, progmem_analog_powerdown_bit, wake0, wake1;
    int          errors = 0;
    int          samples_checked = 0;
    int          p, c_cpu, c_per, c_ser;
    clock_reset_power_modes clock_reset_power_modes_inst (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rst_pin(rst_pin), .speed_double_fuse(fuse),
        .external_fetch_select_pin(fetch_pin), .ext_irq_zero(irq0), .ext_irq_one(irq1), .irq_pending(irq_pending),
        .serial_mode(serial_mode), .timer_baud_tick(baud), .osc_enable_r(osc), .machine_cycle_r(mc),
        .cpu_step_r(cpu), .periph_step_r(per), .serial_tick_r(ser), .core_reset_r(core_reset_r),
        .port_reset_r(port_reset_r), .ext_fetch_latched_r(fetch_r), .progmem_analog_pd_r(progmem_analog_powerdown_bit),
        .wake_irq_zero_r(wake0), .wake_irq_one_r(wake1));
    reset_irq_source reset_irq_source_inst (.mclk(mclk), .pulse_rst(pulse_rst), .pulse_wake0(pulse_wake0),
        .pulse_wake1(pulse_wake1), .rst_pin(rst_pin), .ext_irq_zero(irq0), .ext_irq_one(irq1),
        .timer_baud_tick(baud));
    always #50 mclk = ~mclk;
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Waits as long as the slave needs; only the watchdog ends a hung access.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        chk("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // One idle edge so that the next call never re-raises a strobe in the same step.
        @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk("read", x, exp);
    endtask
    task automatic wait_sig(ref logic sig, input logic v);
        int n;
        n = 0;
        while (sig !== v && n < 500) begin
            @(posedge mclk);
            n++;
        end
        chk("wait", {31'h0, sig}, {31'h0, v});
    endtask
    task automatic period(output int q);
        int n;
        n = 0;
        while (mc !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        q = 1;
        while (mc !== 1'b1 && q < 100) begin
            @(posedge mclk);
            q++;
        end
    endtask
    task automatic count(input int cyc);
        c_cpu = 0;
        c_per = 0;
        c_ser = 0;
        repeat (cyc) begin
            @(posedge mclk);
            c_cpu += (cpu === 1'b1);
            c_per += (per === 1'b1);
            c_ser += (ser === 1'b1);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out;
    end
    initial begin
        mclk = 0; resetn = 0; avs_address = 5'h00; avs_read = 0; avs_write = 0; avs_writedata = 32'h0;
        fuse = 0; fetch_pin = 1; irq_pending = 0; serial_mode = 2'h0; pulse_rst = 0; pulse_wake0 = 0; pulse_wake1 = 0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        wait_sig(rst_pin, 1'b0);
        wait_sig(core_reset_r, 1'b0);
        fetch_pin <= 1'b0;
        rd_chk(5'h10, 32'h00000018);
        chk("fetch", {31'h0, fetch_r}, 32'h1);
        for (int i = 0; i < 4; i++) rd_chk(5'(i * 4), 32'h0);
        wr(5'h14, 32'hFFFFFFFF);
        rd_chk(5'h14, 32'h0);
        period(p);
        chk("period 12", p, 32'd12);
        wr(5'h00, 32'h1);
        period(p);
        chk("period 6", p, 32'd6);
        wr(5'h00, 32'h0);
        wr(5'h04, 32'h10);
        rd_chk(5'h04, 32'h10);
        chk("progmem_analog_powerdown_bit", {31'h0, progmem_analog_powerdown_bit}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            serial_mode <= 2'(m);
            repeat (20) @(posedge mclk);
            count(60);
            chk("serial ticks", c_ser, m[0] ? 32'd12 : 32'd5);
        end
        wr(5'h08, 32'h1);
        repeat (12) @(posedge mclk);
        count(24);
        chk("idle cpu", c_cpu, 32'd0);
        chk("idle periph", c_per, 32'd2);
        rd_chk(5'h08, 32'h1);
        irq_pending <= 1'b1;
        @(posedge mclk);
        irq_pending <= 1'b0;
        repeat (12) @(posedge mclk);
        count(24);
        chk("idle exit", c_cpu, 32'd2);
        wr(5'h0C, 32'h3);
        wr(5'h00, 32'h1);
        wr(5'h08, 32'h2);
        repeat (20) @(posedge mclk);
        chk("osc off", {31'h0, osc}, 32'h0);
        count(24);
        chk("pd periph", c_per, 32'd0);
        rd_chk(5'h10, 32'h00000015);
        pulse_wake0 <= 1'b1;
        @(posedge mclk);
        pulse_wake0 <= 1'b0;
        wait_sig(wake0, 1'b1);
        rd_chk(5'h00, 32'h1);
        rd_chk(5'h10, 32'h00000019);
        count(12);
        chk("resume cpu", c_cpu, 32'd2);
        wr(5'h0C, 32'hC);
        wr(5'h08, 32'h2);
        repeat (20) @(posedge mclk);
        chk("osc off one", {31'h0, osc}, 32'h0);
        pulse_wake1 <= 1'b1;
        @(posedge mclk);
        pulse_wake1 <= 1'b0;
        wait_sig(wake1, 1'b1);
        chk("wake zero quiet", {31'h0, wake0}, 32'h0);
        wr(5'h08, 32'h2);
        repeat (20) @(posedge mclk);
        pulse_rst <= 1'b1;
        @(posedge mclk);
        pulse_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("port reset", {31'h0, port_reset_r}, 32'h1);
        wait_sig(core_reset_r, 1'b1);
        wait_sig(core_reset_r, 1'b0);
        rd_chk(5'h00, 32'h0);
        rd_chk(5'h0C, 32'h0);
        chk("osc on", {31'h0, osc}, 32'h1);
        resetn <= 1'b0;
        fuse <= 1'b1;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        wait_sig(core_reset_r, 1'b0);
        period(p);
        chk("fuse period", p, 32'd6);
        rd_chk(5'h10, 32'h00000029);
        close_out;
    end
endmodule
`default_nettype wire
